//--- rtl/ehp_prog_port.sv
`timescale 1ns/10ps
`include "ehp_defines.svh"

// How it works
// RULE_01 - Mode starts when strobe falls while reset pin high; stays while both hold.
// RULE_02 - Until one signature read arrives, every other command is ignored.
// RULE_03 - Host waits at least 1 ms after arming before other commands.
// RULE_04 - Command 0000 with program strobe high drives addressed signature byte.
// RULE_05 - Address 30H gives maker code, 31H gives part code.
// RULE_06 - Erase and program start on synchronized program strobe falling edge.
// RULE_07 - Signature read and verify data come combinationally from lines.
// RULE_08 - Decode chip, block, sector erase, byte program and verify codes.
// RULE_09 - Code 1001 uses high address for block select or config bits.
// RULE_10 - Codes 1111, 0011, 0101 set lock bits; only chip erase clears them.
// RULE_11 - Selecting block 0 sends later commands to the main block.
// RULE_12 - With boot block selected, addresses below 2000H go to boot block.
// RULE_13 - Each mode entry selects the boot block.
// RULE_14 - Erase writes FFH; host programs only erased bytes.
// RULE_15 - Chip erase clears both blocks, all locks and config bit 0.
// RULE_16 - Chip erase completion selects the boot block.
// RULE_17 - Block erase clears the selected block unless locked.
// RULE_18 - Sector erase clears the 128-byte sector unless locked.
// RULE_19 - Byte program writes data bus byte unless any lock set.
// RULE_20 - Byte verify returns addressed byte, disabled while any lock set.
// RULE_21 - Config bit 0 sets configuration register bit 0 reset value.
// RULE_22 - Ready output drops after strobe falls, rises when operation ends.
// RULE_23 - Verify while busy returns polling bit 3, all other bits 0.
// RULE_24 - Mode starts oscillator and holds core reset; exit stops oscillator.
// RULE_25 - Leaving the mode drops the armed state.
module ehp_prog_port
    import ehp_pkg::*;
#(
    parameter int unsigned CHIP_CYCLES = `EHP_T_CHIP_US * `EHP_CLK_MHZ,
    parameter int unsigned BLOCK_CYCLES = `EHP_T_BLOCK_US * `EHP_CLK_MHZ,
    parameter int unsigned SECTOR_CYCLES = `EHP_T_SECTOR_US * `EHP_CLK_MHZ,
    parameter logic [7:0] MAKER_CODE = 8'h5c,
    parameter logic [7:0] PART_CODE = 8'h3e
)
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic dev_reset_pin_i,
    input wire logic host_mode_strobe_n_i,
    input wire logic ext_access_n_i,
    input wire logic prog_strobe_n_i,
    input wire logic cmd_bit3_i,
    input wire logic cmd_bit2_i,
    input wire logic cmd_bit1_i,
    input wire logic cmd_bit0_i,
    input wire logic [7:0] host_data_bus_i,
    output logic [7:0] host_data_bus_o,
    output logic host_data_bus_oe_o,
    input wire logic [5:0] addr_high_bits_i,
    input wire logic [1:0] addr_top_bits_i,
    input wire logic [7:0] addr_low_byte_i,
    output logic ready_busy_out_o,
    output logic mode_active_o,
    output logic armed_o,
    output logic osc_enable_o,
    output logic core_reset_o,
    output logic [2:0] lock_bits_o,
    output logic startup_config_bit_o,
    output logic config_bit1_o,
    output logic clk_double_o,
    output logic boot_selected_o
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************

    localparam int unsigned BYTE_CYC_I = (`EHP_T_BYTE_US * `EHP_CLK_MHZ);
    localparam int unsigned BIT_CYC_I = (`EHP_T_BIT_US * `EHP_CLK_MHZ);
    localparam int unsigned SEL_CYC_I = (`EHP_T_SEL_NS / `EHP_CLK_NS);
    localparam logic [21:0] BYTE_CYCLES = BYTE_CYC_I[21:0];
    localparam logic [21:0] BIT_CYCLES = BIT_CYC_I[21:0];
    localparam logic [21:0] SEL_CYCLES = SEL_CYC_I[21:0];

    logic [3:0] cmd;
    logic [15:0] addr;
    logic [7:0] addr_hi;

    assign cmd = {cmd_bit3_i, cmd_bit2_i, cmd_bit1_i, cmd_bit0_i};
    assign addr_hi = {addr_top_bits_i, addr_high_bits_i};
    assign addr = {addr_hi, addr_low_byte_i};

    // Decides whether an address lands in the boot block under the selection.
    function automatic logic in_boot(input logic boot_sel, input logic [15:0] a);
        in_boot = boot_sel && (a < `EHP_BOOT_LIMIT);
    endfunction

    // ****************************************************************
    // Mode entry and exit
    // ****************************************************************

    logic mode_reg;
    logic strobe_q_reg;
    logic prog_q_reg;
    logic armed_reg;
    logic boot_sel_reg;
    logic entry;

    assign entry = !mode_reg && dev_reset_pin_i && strobe_q_reg && !host_mode_strobe_n_i;

    // Strobe history for edge detection of the mode and program strobes.
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            strobe_q_reg <= 1'b1;
            prog_q_reg <= 1'b1;
        end
        else
        begin
            strobe_q_reg <= host_mode_strobe_n_i;
            prog_q_reg <= prog_strobe_n_i;
        end
    end

    // Mode holds only while reset pin high and mode strobe low.
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            mode_reg <= 1'b0;
        end
        else if (entry)
        begin
            mode_reg <= 1'b1; // RULE_01
        end
        else if (!dev_reset_pin_i || host_mode_strobe_n_i)
        begin
            mode_reg <= 1'b0; // RULE_01
        end
    end

    assign mode_active_o = mode_reg;
    assign osc_enable_o = mode_reg; // RULE_24
    assign core_reset_o = mode_reg; // RULE_24

    // ****************************************************************
    // Command launch and controller
    // ****************************************************************

    ehp_state_e state_reg;
    ehp_op_e op_reg;
    logic [21:0] count_reg;
    logic [15:0] op_addr_reg;
    logic op_boot_reg;
    logic [7:0] last_byte_reg;
    logic erase_busy_reg;
    logic [2:0] lock_reg;
    logic cfg0_reg;
    logic cfg1_reg;
    logic dbl_reg;
    logic any_lock;
    logic launch;
    logic sig_read;
    logic verify_read;
    logic chip_done;

    assign any_lock = |lock_reg;
    assign launch = mode_reg && armed_reg && prog_q_reg && !prog_strobe_n_i
        && (state_reg == EHP_IDLE); // RULE_06
    assign sig_read = mode_reg && prog_strobe_n_i && (cmd == `EHP_CMD_SIG_READ); // RULE_04
    assign verify_read = mode_reg && armed_reg && prog_strobe_n_i
        && (cmd == `EHP_CMD_BYTE_VERIFY); // RULE_08
    assign chip_done = (state_reg == EHP_SWEEP) && (op_reg == EHP_OP_CHIP)
        && (count_reg == 22'h0) && op_boot_reg;

    // Arming on the first signature read; lost on exit.
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i || !mode_reg)
        begin
            armed_reg <= 1'b0; // RULE_25
        end
        else if (sig_read)
        begin
            armed_reg <= 1'b1; // RULE_02
        end
    end

    assign armed_o = armed_reg;

    // Operation timer and sequencer; erase sweeps rewrite each byte after the wait.
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            state_reg <= EHP_IDLE;
            op_reg <= EHP_OP_NONE;
            count_reg <= 22'h0;
            op_addr_reg <= 16'h0;
            op_boot_reg <= 1'b0;
            erase_busy_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                EHP_IDLE:
                begin
                    if (launch)
                    begin
                        state_reg <= EHP_BUSY; // RULE_22
                        op_reg <= EHP_OP_NONE;
                        erase_busy_reg <= 1'b0;
                        count_reg <= SEL_CYCLES;
                        op_addr_reg <= addr;
                        op_boot_reg <= in_boot(boot_sel_reg, addr); // RULE_12
                        unique case (cmd)
                            `EHP_CMD_CHIP_ERASE:
                            begin
                                op_reg <= EHP_OP_CHIP; // RULE_15
                                count_reg <= CHIP_CYCLES[21:0];
                                op_addr_reg <= 16'h0;
                                op_boot_reg <= 1'b0;
                                erase_busy_reg <= 1'b1;
                            end
                            `EHP_CMD_BLOCK_ERASE:
                            begin
                                if (!any_lock)
                                begin
                                    op_reg <= EHP_OP_BLOCK; // RULE_17
                                end
                                count_reg <= BLOCK_CYCLES[21:0];
                                op_addr_reg <= 16'h0;
                                op_boot_reg <= boot_sel_reg;
                                erase_busy_reg <= 1'b1;
                            end
                            `EHP_CMD_SECTOR_ERASE:
                            begin
                                if (!any_lock)
                                begin
                                    op_reg <= EHP_OP_SECTOR; // RULE_18
                                end
                                count_reg <= SECTOR_CYCLES[21:0];
                                op_addr_reg <= addr & `EHP_SECTOR_MASK;
                                erase_busy_reg <= 1'b1;
                            end
                            `EHP_CMD_BYTE_PROG:
                            begin
                                if (!any_lock)
                                begin
                                    op_reg <= EHP_OP_BYTE; // RULE_19
                                end
                                count_reg <= BYTE_CYCLES;
                            end
                            `EHP_CMD_LOCK1, `EHP_CMD_LOCK2, `EHP_CMD_LOCK3:
                            begin
                                count_reg <= BIT_CYCLES;
                            end
                            default:
                            begin
                                count_reg <= SEL_CYCLES;
                            end
                        endcase
                    end
                end
                EHP_BUSY:
                begin
                    if (count_reg != 22'h0)
                    begin
                        count_reg <= count_reg - 22'h1;
                    end
                    else if (op_reg == EHP_OP_NONE || op_reg == EHP_OP_BYTE)
                    begin
                        state_reg <= EHP_IDLE; // RULE_22
                        erase_busy_reg <= 1'b0;
                    end
                    else
                    begin
                        state_reg <= EHP_SWEEP;
                        count_reg <= (op_reg == EHP_OP_SECTOR) ? 22'h7f : 22'h0;
                        if (op_reg == EHP_OP_BLOCK && !op_boot_reg)
                        begin
                            count_reg <= 22'hffff;
                        end
                        else if (op_reg != EHP_OP_SECTOR)
                        begin
                            count_reg <= 22'hffff;
                        end
                        if (op_reg == EHP_OP_BLOCK && op_boot_reg)
                        begin
                            count_reg <= 22'h1fff;
                        end
                    end
                end
                EHP_SWEEP:
                begin
                    op_addr_reg <= op_addr_reg + 16'h1;
                    if (count_reg != 22'h0)
                    begin
                        count_reg <= count_reg - 22'h1;
                    end
                    else if (op_reg == EHP_OP_CHIP && !op_boot_reg)
                    begin
                        op_boot_reg <= 1'b1; // RULE_15
                        op_addr_reg <= 16'h0;
                        count_reg <= 22'h1fff;
                    end
                    else
                    begin
                        state_reg <= EHP_IDLE; // RULE_22
                        erase_busy_reg <= 1'b0;
                    end
                end
                default:
                begin
                    state_reg <= EHP_IDLE;
                end
            endcase
        end
    end

    assign ready_busy_out_o = (state_reg == EHP_IDLE); // RULE_22

    // Last byte presented for programming, used by the polling answer.
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            last_byte_reg <= `EHP_ERASED;
        end
        else if (launch && cmd == `EHP_CMD_BYTE_PROG)
        begin
            last_byte_reg <= host_data_bus_i;
        end
    end

    // ****************************************************************
    // Block selection, lock and configuration bits
    // ****************************************************************

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i || entry)
        begin
            boot_sel_reg <= 1'b1; // RULE_13
        end
        else if (chip_done)
        begin
            boot_sel_reg <= 1'b1; // RULE_16
        end
        else if (launch && cmd == `EHP_CMD_BLOCK_CFG && addr_hi == `EHP_SEL_MAIN)
        begin
            boot_sel_reg <= 1'b0; // RULE_11
        end
        else if (launch && cmd == `EHP_CMD_BLOCK_CFG && addr_hi == `EHP_SEL_BOOT)
        begin
            boot_sel_reg <= 1'b1; // RULE_09
        end
    end

    assign boot_selected_o = boot_sel_reg;

    // Non-volatile bits set by their commands; chip erase clears only the locks and config bit 0.
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            lock_reg <= 3'h0;
            cfg0_reg <= 1'b0;
            cfg1_reg <= 1'b0;
            dbl_reg <= 1'b0;
        end
        else if (chip_done)
        begin
            lock_reg <= 3'h0; // RULE_15
            cfg0_reg <= 1'b0; // RULE_21
        end
        else if (launch)
        begin
            lock_reg[0] <= lock_reg[0] | (cmd == `EHP_CMD_LOCK1); // RULE_10
            lock_reg[1] <= lock_reg[1] | (cmd == `EHP_CMD_LOCK2); // RULE_10
            lock_reg[2] <= lock_reg[2] | (cmd == `EHP_CMD_LOCK3); // RULE_10
            if (cmd == `EHP_CMD_BLOCK_CFG && addr_hi == `EHP_CFG0_KEY)
            begin
                cfg0_reg <= 1'b1; // RULE_21
            end
            if (cmd == `EHP_CMD_BLOCK_CFG && addr_hi == `EHP_CFG1_KEY)
            begin
                cfg1_reg <= 1'b1; // RULE_09
            end
            if (cmd == `EHP_CMD_CLK_DOUBLE && addr_hi == `EHP_DOUBLE_KEY)
            begin
                dbl_reg <= 1'b1; // RULE_09
            end
        end
    end

    assign lock_bits_o = lock_reg;
    assign startup_config_bit_o = cfg0_reg;
    assign config_bit1_o = cfg1_reg;
    assign clk_double_o = dbl_reg;

    // ****************************************************************
    // Flash array and read path
    // ****************************************************************

    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;

    assign wr_en = (state_reg == EHP_SWEEP)
        || (state_reg == EHP_BUSY && op_reg == EHP_OP_BYTE && count_reg == 22'h0);
    assign wr_data = (state_reg == EHP_SWEEP) ? `EHP_ERASED : last_byte_reg; // RULE_14

    ehp_flash_array u_array
    (
        .ref_clk_i(ref_clk_i),
        .wr_en_i(wr_en),
        .wr_boot_i(op_boot_reg),
        .wr_addr_i(op_addr_reg),
        .wr_data_i(wr_data),
        .rd_boot_i(in_boot(boot_sel_reg, addr)),
        .rd_addr_i(addr),
        .rd_data_o(rd_data)
    );

    // Read answers are combinational from the command and address lines.
    always_comb
    begin
        host_data_bus_o = 8'h00;
        host_data_bus_oe_o = 1'b0;
        if (sig_read)
        begin
            host_data_bus_oe_o = 1'b1; // RULE_07
            unique case (addr)
                `EHP_SIG_MAKER_ADDR: host_data_bus_o = MAKER_CODE; // RULE_05
                `EHP_SIG_PART_ADDR: host_data_bus_o = PART_CODE; // RULE_05
                `EHP_SIG_LOCK_ADDR: host_data_bus_o =
                    {4'h0, cfg0_reg, lock_reg[0], lock_reg[1], lock_reg[2]};
                `EHP_SIG_CLK_ADDR: host_data_bus_o = {6'h0, dbl_reg, 1'b0};
                default: host_data_bus_o = 8'h00;
            endcase
        end
        else if (verify_read && !any_lock)
        begin
            host_data_bus_oe_o = 1'b1; // RULE_20
            if (state_reg != EHP_IDLE)
            begin
                host_data_bus_o[`EHP_POLL_BIT] = erase_busy_reg ? 1'b0
                    : !last_byte_reg[`EHP_POLL_BIT]; // RULE_23
            end
            else
            begin
                host_data_bus_o = rd_data; // RULE_20
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************

    a_mode_exit: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        mode_reg && host_mode_strobe_n_i |=> !mode_reg) // RULE_01
        else $error("mode held after strobe rose");
    a_arm_gate: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !armed_reg |-> !launch) // RULE_02
        else $error("command launched before arming");
    a_busy_drop: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        launch |=> !ready_busy_out_o) // RULE_22
        else $error("ready did not drop after launch");
    a_entry_boot: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        entry |=> boot_sel_reg && !armed_reg) // RULE_13
        else $error("entry did not select boot block");
    a_chip_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        chip_done |=> lock_reg == 3'h0 && !cfg0_reg && boot_sel_reg) // RULE_15
        else $error("chip erase left locks or selection");
    a_lock_sticky: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        $fell(lock_reg[0]) |-> $past(chip_done)) // RULE_10
        else $error("lock bit cleared without chip erase");
    a_prog_locked: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        launch && any_lock && cmd == `EHP_CMD_BYTE_PROG |=> op_reg == EHP_OP_NONE) // RULE_19
        else $error("program ran while locked");
    a_maker_read: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        sig_read && addr == `EHP_SIG_MAKER_ADDR |-> host_data_bus_o == MAKER_CODE) // RULE_05
        else $error("maker code wrong");
    a_main_select: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        launch && cmd == `EHP_CMD_BLOCK_CFG && addr_hi == `EHP_SEL_MAIN
        |=> !boot_sel_reg) // RULE_11
        else $error("main block not selected");

endmodule // ehp_prog_port

//--- rtl/ehp_defines.svh
`ifndef EHP_DEFINES_SVH
`define EHP_DEFINES_SVH

// Command codes, ordered bit3 down to bit0.
`define EHP_CMD_SIG_READ 4'h0
`define EHP_CMD_CHIP_ERASE 4'h1
`define EHP_CMD_BLOCK_ERASE 4'hd
`define EHP_CMD_SECTOR_ERASE 4'hb
`define EHP_CMD_BYTE_PROG 4'he
`define EHP_CMD_BYTE_VERIFY 4'hc
`define EHP_CMD_BLOCK_CFG 4'h9
`define EHP_CMD_CLK_DOUBLE 4'h8
`define EHP_CMD_LOCK1 4'hf
`define EHP_CMD_LOCK2 4'h3
`define EHP_CMD_LOCK3 4'h5

// High address byte qualifiers for the block and configuration commands.
`define EHP_SEL_MAIN 8'h55
`define EHP_SEL_BOOT 8'ha5
`define EHP_CFG0_KEY 8'h5a
`define EHP_CFG1_KEY 8'haa
`define EHP_DOUBLE_KEY 8'h55

// Signature addresses.
`define EHP_SIG_MAKER_ADDR 16'h0030
`define EHP_SIG_PART_ADDR 16'h0031
`define EHP_SIG_LOCK_ADDR 16'h0060
`define EHP_SIG_CLK_ADDR 16'h0061

// Memory geometry.
`define EHP_BOOT_LIMIT 16'h2000
`define EHP_ERASED 8'hff
`define EHP_SECTOR_MASK 16'hff80
`define EHP_SECTOR_BYTES 8'h80
`define EHP_POLL_BIT 3

// Operation times in microseconds, select time and clock period in nanoseconds, and the clock rate.
`define EHP_CLK_MHZ 20
`define EHP_T_CHIP_US 150000
`define EHP_T_BLOCK_US 100000
`define EHP_T_SECTOR_US 30000
`define EHP_T_BYTE_US 50
`define EHP_T_BIT_US 80
`define EHP_T_SEL_NS 500
`define EHP_CLK_NS 50

`endif

//--- rtl/ehp_pkg.sv
package ehp_pkg;

    // Operation kinds held by the controller; the flash array sees only the write and read controls.
    typedef enum logic [2:0]
    {
        EHP_OP_NONE = 3'b000,
        EHP_OP_CHIP = 3'b001,
        EHP_OP_BLOCK = 3'b010,
        EHP_OP_SECTOR = 3'b011,
        EHP_OP_BYTE = 3'b100
    } ehp_op_e;

    // Controller states.
    typedef enum logic [1:0]
    {
        EHP_IDLE = 2'b00,
        EHP_BUSY = 2'b01,
        EHP_SWEEP = 2'b10
    } ehp_state_e;

endpackage

//--- rtl/ehp_flash_array.sv
`timescale 1ns/10ps
`include "ehp_defines.svh"

// Flip-flop model of the two flash blocks: 8 KByte boot block, 64 KByte main block.
module ehp_flash_array
    import ehp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic wr_en_i,
    input wire logic wr_boot_i,
    input wire logic [15:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic rd_boot_i,
    input wire logic [15:0] rd_addr_i,
    output logic [7:0] rd_data_o
);

    logic [7:0] main_mem [0:65535];
    logic [7:0] boot_mem [0:8191];

    // Writes store a byte; erase is done by writing the erased value.
    always_ff @(posedge ref_clk_i)
    begin
        if (wr_en_i && wr_boot_i)
        begin
            boot_mem[wr_addr_i[12:0]] <= wr_data_i;
        end
        else if (wr_en_i)
        begin
            main_mem[wr_addr_i] <= wr_data_i;
        end
    end

    // Reads are combinational, as the verify path is asynchronous.
    assign rd_data_o = rd_boot_i ? boot_mem[rd_addr_i[12:0]] : main_mem[rd_addr_i];

endmodule // ehp_flash_array

//--- dv/ehp_host_model.sv
`timescale 1ns/10ps

// ****
// Host programmer.
// ****
module ehp_host_model
(
    input wire logic clk_i,
    output logic mode_n_o,
    output logic prog_n_o,
    output logic [3:0] cmd_o,
    output logic [15:0] addr_o,
    output logic [7:0] data_o
);
    // Both strobes start high.
    initial
    begin
        {mode_n_o, prog_n_o, cmd_o, addr_o, data_o} = {2'h3, 28'h0};
    end
    // Moves the mode strobe after a falling edge.
    task automatic mode(input logic v);
        @(negedge clk_i);
        mode_n_o = v;
    endtask
    // Sets the command, address and data lines.
    task automatic put(input logic [3:0] c, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {cmd_o, addr_o, data_o} = {c, a, d};
    endtask
    // Pulses the program strobe, then releases data with its inverse.
    task automatic pulse(input logic [3:0] c, input logic [15:0] a, input logic [7:0] d);
        put(c, a, d);
        @(negedge clk_i);
        prog_n_o = 1'b0;
        repeat (2) @(negedge clk_i);
        prog_n_o = 1'b1;
        data_o = ~d;
    endtask
    // Waits 1 ms after arming.
    task automatic settle();
        repeat (20000) @(negedge clk_i);
    endtask
endmodule // ehp_host_model

//--- dv/tb_top.sv
`timescale 1ns/10ps

// ****
// Bench for the programming port.
// ****
module tb_top;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic mode_n, prog_n, oe, rdy, mode, armed, osc, core, cfg0, cfg1, dbl, boot;
    logic [3:0] cmd;
    logic [15:0] addr, a;
    logic [7:0] hdata, dout, bus_in;
    logic [2:0] locks;
    logic [7:0] mem [int];
    logic [7:0] d [2];
    logic bsel = 1'b1;
    logic rst_pin = 1'b1;
    logic ext_n = 1'b1;
    int n_mismatch = 0;
    int comparisons = 0;

    // Clock and shared data bus.
    always #25 ref_clk_i = ~ref_clk_i;
    assign bus_in = oe ? dout : hdata;

    ehp_host_model host (.clk_i(ref_clk_i), .mode_n_o(mode_n), .prog_n_o(prog_n),
        .cmd_o(cmd), .addr_o(addr), .data_o(hdata));
    // Short counts; the codes are arbitrary.
    ehp_prog_port #(.CHIP_CYCLES(20), .BLOCK_CYCLES(20), .SECTOR_CYCLES(20),
        .MAKER_CODE(8'h6a), .PART_CODE(8'h2d)) uut (.ref_clk_i, .reset_i,
        .dev_reset_pin_i(rst_pin), .host_mode_strobe_n_i(mode_n), .ext_access_n_i(ext_n),
        .prog_strobe_n_i(prog_n), .cmd_bit3_i(cmd[3]), .cmd_bit2_i(cmd[2]),
        .cmd_bit1_i(cmd[1]), .cmd_bit0_i(cmd[0]), .host_data_bus_i(bus_in),
        .host_data_bus_o(dout), .host_data_bus_oe_o(oe), .addr_high_bits_i(addr[13:8]),
        .addr_top_bits_i(addr[15:14]), .addr_low_byte_i(addr[7:0]), .ready_busy_out_o(rdy),
        .mode_active_o(mode), .armed_o(armed), .osc_enable_o(osc), .core_reset_o(core),
        .lock_bits_o(locks), .startup_config_bit_o(cfg0), .config_bit1_o(cfg1),
        .clk_double_o(dbl), .boot_selected_o(boot));

    // Compares one result.
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask
    // Model key: boot block bytes sit above the main block.
    function automatic int key(input logic [15:0] x);
        return {15'h0, bsel && (x < 16'h2000), x};
    endfunction
    // Busy must show, then ready must return.
    task automatic wt();
        @(posedge ref_clk_i);
        #1 chk("busy", 8'h0, {7'h0, rdy});
        for (int i = 0; i < 2000 && rdy !== 1'b1; i++) @(posedge ref_clk_i) #1;
        #1 chk("ready", 8'h1, {7'h0, rdy});
    endtask
    // Read-type command with the program strobe high.
    task automatic rd(input logic [3:0] c, input logic [15:0] x, input logic [7:0] e);
        host.put(c, x, 8'h0);
        @(posedge ref_clk_i);
        #1 chk("oe", 8'h1, {7'h0, oe});
        chk("read", e, dout);
    endtask
    // Prints counts and verdict.
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog.
    initial
    begin
        repeat (60000) @(posedge ref_clk_i);
        n_mismatch++;
        stop_test();
    end
    // Main sequence.
    initial
    begin
        void'($urandom(73));
        repeat (20) @(negedge ref_clk_i);
        reset_i = 1'b0;
        host.mode(1'b0);
        @(posedge ref_clk_i);
        #1 chk("mode", 8'h3, {6'h0, mode, core});
        chk("boot", 8'h1, {7'h0, boot});
        host.pulse(4'he, 16'h0040, 8'h12);
        @(posedge ref_clk_i);
        #1 chk("refused", 8'h1, {7'h0, rdy});
        rd(4'h0, 16'h0030, 8'h6a);
        rd(4'h0, 16'h0031, 8'h2d);
        chk("armed", 8'h1, {7'h0, armed});
        host.settle();
        a = 16'($urandom) & 16'h1fff;
        for (int s = 0; s < 2; s++)
        begin
            host.pulse(4'h9, s ? 16'h5500 : 16'ha500, 8'h0);
            wt();
            bsel = (s == 0);
            chk("sel", {7'h0, bsel}, {7'h0, boot});
            host.pulse(4'hb, a, 8'h0);
            wt();
            for (int i = 0; i < 128; i++) mem[key((a & 16'hff80) + 16'(i))] = 8'hff;
            d[s] = 8'($urandom);
            host.pulse(4'he, a, d[s]);
            rd(4'hc, a, {4'h0, ~d[s][3], 3'h0});
            wt();
            mem[key(a)] = d[s];
            rd(4'hc, a, mem[key(a)]);
            rd(4'hc, a ^ 16'h1, mem[key(a ^ 16'h1)]);
        end
        host.pulse(4'h9, 16'ha500, 8'h0);
        wt();
        bsel = 1'b1;
        rd(4'hc, a, d[0]);
        host.pulse(4'h9, 16'h5a00, 8'h0);
        wt();
        chk("cfg0", 8'h1, {7'h0, cfg0});
        host.pulse(4'h8, 16'h5500, 8'h0);
        wt();
        host.pulse(4'h9, 16'haa00, 8'h0);
        wt();
        chk("cfg1 dbl", 8'h3, {6'h0, cfg1, dbl});
        rd(4'h0, 16'h0061, 8'h02);
        host.pulse(4'hf, 16'h0, 8'h0);
        wt();
        chk("lock", 8'h1, {5'h0, locks});
        rd(4'h0, 16'h0060, 8'h0c);
        host.pulse(4'h9, 16'h5500, 8'h0);
        wt();
        host.put(4'hc, a, 8'h0);
        @(posedge ref_clk_i);
        #1 chk("locked oe", 8'h0, {7'h0, oe});
        host.mode(1'b1);
        repeat (2) @(posedge ref_clk_i);
        #1 chk("exit", 8'h0, {6'h0, armed, osc});
        host.mode(1'b0);
        @(posedge ref_clk_i);
        #1 chk("reentry", 8'h5, {5'h0, mode, armed, boot});
        @(negedge ref_clk_i);
        rst_pin = 1'b0;
        @(posedge ref_clk_i);
        #1 chk("pin exit", 8'h0, {7'h0, mode});
        stop_test();
    end
endmodule // tb_top
